// file: hw/azd_regs.svh
// Field positions, codes and reset values for the calibration and duty readback
`ifndef AZD_REGS_SVH
`define AZD_REGS_SVH
`define AZD_RW_BIT        31
`define AZD_ID_HI         30
`define AZD_ID_LO         26
`define AZD_CH_HI         25
`define AZD_CH_LO         24
`define AZD_ID_CAL_STATUS 5'h0b
`define AZD_ID_DUTY       5'h0c
`define AZD_OVL_BIT       15
`define AZD_PSL_BIT       14
`define AZD_CLO_BIT       13
`define AZD_CHI_BIT       12
`define AZD_OFS_LO_HI     11
`define AZD_OFS_LO_LO     6
`define AZD_OFS_HI_HI     5
`define AZD_OFS_HI_LO     0
`define AZD_DUTY_HI       18
`define AZD_DUTY_LO       0
`define AZD_WORD_ZERO     32'h0000_0000
`define AZD_OFS_RESET     6'h00
`define AZD_DUTY_DIV      32
`endif

// file: hw/azd_pkg.sv
// Types shared by the readback logic
package azd_pkg;
   typedef struct packed {
      logic        valid;
      logic [4:0]  message_identifier;
      logic [1:0]  channel;
   } azd_query_t;
   typedef struct packed {
      logic [5:0] ofs_low_cm;
      logic [5:0] ofs_high_cm;
   } azd_cal_t;
endpackage : azd_pkg

// file: hw/azd_event_latch.sv
// Sticky event latch with set-over-clear priority
`timescale 1ns/10ps
`default_nettype none
module azd_event_latch (
   input  wire logic i_sys_clk,
   input  wire logic i_reset_n,
   input  wire logic i_set,
   input  wire logic i_clear,
   output var  logic o_flag
);
   // Set wins so an event in the clearing cycle is kept
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clear) begin
         o_flag <= 1'b0;
      end
   end
endmodule : azd_event_latch
`default_nettype wire

// file: hw/azd_readback.sv
// Calibration status and duty-cycle readback word builder
`timescale 1ns/10ps
`default_nettype none
`include "azd_regs.svh"
// How it works
// - The calibration answer has bit 31 low, identifier and channel echoed, bits 23:16 zero.
// - The overvoltage latch in bit 15 sets while the battery supply is over threshold.
// - The overvoltage latch clears only on a calibration query while the supply is below threshold.
// - The phase-sync latch in bit 14 sets on each sync rising edge and clears on a calibration query.
// - Bit 13 sets when calibration ends at low common mode and clears on a calibration query.
// - Bit 12 sets when calibration ends at high common mode and clears on a calibration query.
// - Bits 11:6 report the stored low common-mode offset value.
// - Bits 5:0 report the stored high common-mode offset value.
// - The duty answer has bit 31 low, identifier and channel echoed, bits 23:19 zero, duty in 18:0.
// - The duty count is scaled so that percent equals count over 32 times N, times 100.
module azd_readback #(
   parameter int DUTY_W = 19
) (
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_reset_n,
   input  wire azd_pkg::azd_query_t    i_query,
   input  wire logic                   i_battery_over,
   input  wire logic                   i_phase_sync,
   input  wire logic                   i_cal_done,
   input  wire logic                   i_cal_high_cm,
   input  wire azd_pkg::azd_cal_t      i_cal_value,
   input  wire logic [4*DUTY_W-1:0]    i_duty_count,
   output var  logic [31:0]            o_response,
   output var  logic                   o_response_valid
);
   initial begin
      if (DUTY_W != `AZD_DUTY_HI - `AZD_DUTY_LO + 1) begin
         $error("DUTY_W must match the duty field width");
      end
   end

   logic                 cal_query;
   logic                 duty_query;
   logic                 sync_prev_reg;
   logic                 overvoltage_latch;
   logic                 phase_sync_latch;
   logic                 cal_low_cm_done;
   logic                 cal_high_cm_done;
   azd_pkg::azd_cal_t    cal_store_reg;
   logic [DUTY_W-1:0]    duty_sel;

   // Identifier decode; the write flag is ignored so writes act as reads
   assign cal_query  = i_query.valid &&
                       (i_query.message_identifier == `AZD_ID_CAL_STATUS);
   assign duty_query = i_query.valid &&
                       (i_query.message_identifier == `AZD_ID_DUTY);

   // Pick the queried channel's duty count
   function automatic logic [DUTY_W-1:0] pick_duty(input logic [4*DUTY_W-1:0] all,
                                                   input logic [1:0] ch);
      pick_duty = all[ch*DUTY_W +: DUTY_W];
   endfunction : pick_duty
   assign duty_sel = pick_duty(i_duty_count, i_query.channel);

   // Edge detect on the sync input for the phase latch
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         sync_prev_reg <= 1'b0;
      end else begin
         sync_prev_reg <= i_phase_sync;
      end
   end

   // Overvoltage cannot clear while the supply is still high
   azd_event_latch u_ovl (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_set     (i_battery_over),
      .i_clear   (cal_query && !i_battery_over),
      .o_flag    (overvoltage_latch)
   );
   azd_event_latch u_psl (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_set     (i_phase_sync && !sync_prev_reg),
      .i_clear   (cal_query),
      .o_flag    (phase_sync_latch)
   );
   azd_event_latch u_clo (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_set     (i_cal_done && !i_cal_high_cm),
      .i_clear   (cal_query),
      .o_flag    (cal_low_cm_done)
   );
   azd_event_latch u_chi (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_set     (i_cal_done && i_cal_high_cm),
      .i_clear   (cal_query),
      .o_flag    (cal_high_cm_done)
   );

   // Offsets are captured when a calibration finishes
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         cal_store_reg <= {`AZD_OFS_RESET, `AZD_OFS_RESET};
      end else if (i_cal_done) begin
         if (i_cal_high_cm) begin
            cal_store_reg.ofs_high_cm <= i_cal_value.ofs_high_cm;
         end else begin
            cal_store_reg.ofs_low_cm <= i_cal_value.ofs_low_cm;
         end
      end
   end

   // Answer word; latches reported before their clear takes effect
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_response       <= `AZD_WORD_ZERO;
         o_response_valid <= 1'b0;
      end else begin
         o_response_valid <= cal_query || duty_query;
         if (cal_query) begin
            o_response <= `AZD_WORD_ZERO;
            o_response[`AZD_ID_HI:`AZD_ID_LO] <= i_query.message_identifier;
            o_response[`AZD_CH_HI:`AZD_CH_LO] <= i_query.channel;
            o_response[`AZD_OVL_BIT] <= overvoltage_latch || i_battery_over;
            o_response[`AZD_PSL_BIT] <= phase_sync_latch;
            o_response[`AZD_CLO_BIT] <= cal_low_cm_done;
            o_response[`AZD_CHI_BIT] <= cal_high_cm_done;
            o_response[`AZD_OFS_LO_HI:`AZD_OFS_LO_LO] <= cal_store_reg.ofs_low_cm;
            o_response[`AZD_OFS_HI_HI:`AZD_OFS_HI_LO] <= cal_store_reg.ofs_high_cm;
         end else if (duty_query) begin
            o_response <= `AZD_WORD_ZERO;
            o_response[`AZD_ID_HI:`AZD_ID_LO] <= i_query.message_identifier;
            o_response[`AZD_CH_HI:`AZD_CH_LO] <= i_query.channel;
            // Count is already in 1/(32*N) units of the period
            o_response[`AZD_DUTY_HI:`AZD_DUTY_LO] <= duty_sel;
         end
      end
   end

   chk_ovl_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      i_battery_over |=> overvoltage_latch)
      else $error("overvoltage latch dropped while supply high");
   chk_ovl_clear: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query && !i_battery_over |=> !overvoltage_latch)
      else $error("overvoltage latch not cleared by query");
   chk_psl_edge: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      $rose(i_phase_sync) |=> phase_sync_latch)
      else $error("phase latch missed sync edge");
   chk_clo_set: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cal_done && !i_cal_high_cm |=> cal_low_cm_done)
      else $error("low cm done not set");
   chk_chi_set: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cal_done && i_cal_high_cm |=> cal_high_cm_done)
      else $error("high cm done not set");
   chk_cal_header: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query |=> o_response_valid && o_response[31:16] ==
         {1'b0, `AZD_ID_CAL_STATUS, $past(i_query.channel), 8'h00})
      else $error("bad calibration header");
   chk_cal_clear: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query && !i_phase_sync |=> !phase_sync_latch)
      else $error("phase latch not cleared by query");
   chk_ofs_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query |=> o_response[11:0] == $past(cal_store_reg))
      else $error("offsets misreported");
   chk_duty_word: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      duty_query |=> o_response_valid && o_response[31:19] ==
         {1'b0, `AZD_ID_DUTY, $past(i_query.channel), 5'h00}
         && o_response[18:0] == $past(duty_sel))
      else $error("bad duty word");
   chk_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      !(cal_query || duty_query) |=> !o_response_valid)
      else $error("answer without query");

   // Supply still high at query time must show in the answer
   chk_ovl_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query && i_battery_over |=> o_response[`AZD_OVL_BIT])
      else $error("overvoltage not reported");
   // A stored overvoltage event is reported even after the supply drops
   chk_ovl_latched: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query && overvoltage_latch |=> o_response[`AZD_OVL_BIT])
      else $error("stored overvoltage not reported");
   // Answer shows the phase latch as it stood before the clear
   chk_psl_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query |=> o_response[`AZD_PSL_BIT] == $past(phase_sync_latch))
      else $error("phase latch misreported");
   // Low common-mode done bit reported before its clear
   chk_clo_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query |=> o_response[`AZD_CLO_BIT] == $past(cal_low_cm_done))
      else $error("low cm done misreported");
   // High common-mode done bit reported before its clear
   chk_chi_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query |=> o_response[`AZD_CHI_BIT] == $past(cal_high_cm_done))
      else $error("high cm done misreported");
   // Query clears the low common-mode flag unless a new event lands
   chk_clo_clear: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query && !(i_cal_done && !i_cal_high_cm) |=> !cal_low_cm_done)
      else $error("low cm done not cleared");
   // Query clears the high common-mode flag unless a new event lands
   chk_chi_clear: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      cal_query && !(i_cal_done && i_cal_high_cm) |=> !cal_high_cm_done)
      else $error("high cm done not cleared");
   // Low common-mode offset captured only from its own calibration
   chk_ofs_low_cap: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cal_done && !i_cal_high_cm |=> cal_store_reg.ofs_low_cm == $past(i_cal_value.ofs_low_cm))
      else $error("low cm offset not stored");
   // High common-mode offset captured only from its own calibration
   chk_ofs_high_cap: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cal_done && i_cal_high_cm |=> cal_store_reg.ofs_high_cm == $past(i_cal_value.ofs_high_cm))
      else $error("high cm offset not stored");
   // Answer word holds between accepted queries
   chk_resp_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      !(cal_query || duty_query) |=> $stable(o_response))
      else $error("answer word changed without query");

endmodule : azd_readback
`default_nettype wire

// file: tb/azd_host_model.sv
// Host model that issues calibration and duty queries
`timescale 1ns/10ps
`default_nettype none
module azd_host_model (
   input  wire logic              i_sys_clk,
   output var  azd_pkg::azd_query_t o_query
);
   initial o_query = '0;
   // One-cycle query, launched just after an edge; write flag dropped as it reads anyway
   task automatic send(input logic [4:0] id, input logic [1:0] ch);
      @(posedge i_sys_clk);
      o_query <= '{1'b1, id, ch};
      @(posedge i_sys_clk);
      o_query <= '0;
   endtask : send
endmodule : azd_host_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the calibration and duty readback
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic                i_sys_clk = 1'b0;
   logic                i_reset_n = 1'b0;
   logic                battery_supply_input       = 1'b0;
   logic                sync      = 1'b0;
   logic                cdone     = 1'b0;
   logic                chi       = 1'b0;
   azd_pkg::azd_query_t query;
   azd_pkg::azd_cal_t   calv      = '0;
   logic [75:0]         duty      = '0;
   logic [31:0]         resp;
   logic                rv;
   int                  num_errors = 0;
   int                  n_tests    = 0;
   // Per-channel duty counts; expectations read this constant, not the live bus
   localparam logic [75:0] DUTY_SET = {19'h7ffff, 19'h00001, 19'h2aaaa, 19'h15555};
   // Free-running 50 MHz clock
   always #10 i_sys_clk = ~i_sys_clk;
   azd_host_model host (.i_sys_clk(i_sys_clk), .o_query(query));
   azd_readback DUT (
      .i_sys_clk       (i_sys_clk),
      .i_reset_n       (i_reset_n),
      .i_query         (query),
      .i_battery_over  (battery_supply_input),
      .i_phase_sync    (sync),
      .i_cal_done      (cdone),
      .i_cal_high_cm   (chi),
      .i_cal_value     (calv),
      .i_duty_count    (duty),
      .o_response      (resp),
      .o_response_valid(rv)
   );
   // Expected calibration word built from the field layout
   function automatic logic [31:0] cw(logic [1:0] ch, logic [3:0] fl, logic [11:0] ofs);
      return {1'b0, 5'h0b, ch, 8'h00, fl, ofs};
   endfunction : cw
   // Query, then look at the one-cycle answer once the edge has settled
   task automatic ask(input logic [4:0] id, input logic [1:0] ch, input logic [31:0] exp);
      host.send(id, ch);
      #1;
      `CHK("valid", 1'b1, rv)
      `CHK("word", exp, resp)
   endtask : ask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // Main sequence
   initial begin
      repeat (16) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      ask(5'h0b, 2'd0, cw(2'd0, 4'h0, 12'h000));
      @(posedge i_sys_clk);
      battery_supply_input   <= 1'b1;
      sync  <= 1'b1;
      cdone <= 1'b1;
      calv  <= '{6'h2a, 6'h35};
      @(posedge i_sys_clk);
      battery_supply_input   <= 1'b0;
      chi   <= 1'b1;
      calv  <= '{6'h11, 6'h3f};
      @(posedge i_sys_clk);
      cdone <= 1'b0;
      ask(5'h0b, 2'd3, cw(2'd3, 4'hf, {6'h2a, 6'h3f}));
      ask(5'h0b, 2'd1, cw(2'd1, 4'h0, {6'h2a, 6'h3f}));
      // Supply high during a query keeps the overvoltage latch
      @(posedge i_sys_clk);
      battery_supply_input  <= 1'b1;
      sync <= 1'b0;
      ask(5'h0b, 2'd2, cw(2'd2, 4'h8, {6'h2a, 6'h3f}));
      battery_supply_input  <= 1'b0;
      sync <= 1'b1;
      ask(5'h0b, 2'd2, cw(2'd2, 4'hc, {6'h2a, 6'h3f}));
      ask(5'h0b, 2'd0, cw(2'd0, 4'h0, {6'h2a, 6'h3f}));
      // Distinct counts per channel, top one at full scale
      duty <= DUTY_SET;
      for (int c = 0; c < 4; c++)
         ask(5'h0c, c[1:0], {1'b0, 5'h0c, c[1:0], 5'h00, DUTY_SET[19*c +: 19]});
      host.send(5'h0a, 2'd0);
      #1;
      `CHK("ignored", 1'b0, rv)
      `CHK("held", {1'b0, 5'h0c, 2'd3, 5'h00, 19'h7ffff}, resp)
      tally_and_finish();
   end
   // Hang guard, far beyond the forty-odd cycles the sequence needs
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
